// *** include/fcp_regs.vh ***
`ifndef FCP_REGS_VH
`define FCP_REGS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define FCP_ADDR_STATUS 8'hf8
`define FCP_ADDR_PROTECT 8'hf9
`define FCP_ADDR_ERASE 8'hfa
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define FCP_BIT_DEBUG 7
`define FCP_BIT_STP 6
`define FCP_BIT_WEN 5
`define FCP_BIT_READY_LOW_FLAG 4
`define FCP_BIT_REDIR 3
`define FCP_BIT_RBP 2
`define FCP_BIT_RSV1 1
`define FCP_BIT_RSV0 0
// ----------------------------------------
// Configuration page layout
// ----------------------------------------
`define FCP_CFG_UNPROTECTED_PAGE_COUNT 9'h020
`define FCP_CFG_RBP 9'h023
`define FCP_CFG_DEBUG 9'h024
`define FCP_CFG_BYTES 10'h200
`define FCP_UNSET 8'hff
// ----------------------------------------
// Geometry and reset values
// ----------------------------------------
`define FCP_CODE_PAGES 8'h20
`define FCP_ERASE_LIMIT 8'h24
`define FCP_PAGE_BYTES 10'h200
`define FCP_PARITY_BYTES 5'h10
`define FCP_RST_ERASE 8'h00
`define FCP_RST_PROTECT 8'hff
`endif

// *** verilog/fcp_flash_config.v ***
`timescale 1ns/1ps
`include "fcp_regs.vh"
module fcp_flash_config (
    sys_clk,
    rst,
    boot_rd_addr,
    boot_rd_en,
    boot_rd_data,
    boot_rd_valid,
    sfr_addr,
    sfr_wr,
    sfr_wdata,
    sfr_rdata,
    spi_sr_wr,
    spi_sr_wdata,
    spi_wren,
    spi_wrdis,
    spi_rbp_cmd,
    spi_req,
    spi_req_erase,
    spi_req_write,
    spi_erase_all,
    spi_sr_rdata,
    spi_grant,
    spi_to_config,
    spi_erase_all_go,
    mcu_req,
    mcu_req_write,
    mcu_page,
    mcu_grant,
    page_erase_go,
    page_erase_num,
    debug_on,
    start_page,
    nvm_reserved
);
    input wire sys_clk;
    input wire rst;
    output reg [8:0] boot_rd_addr;
    output reg boot_rd_en;
    input wire [7:0] boot_rd_data;
    input wire boot_rd_valid;
    input wire [7:0] sfr_addr;
    input wire sfr_wr;
    input wire [7:0] sfr_wdata;
    output reg [7:0] sfr_rdata;
    input wire spi_sr_wr;
    input wire [7:0] spi_sr_wdata;
    input wire spi_wren;
    input wire spi_wrdis;
    input wire spi_rbp_cmd;
    input wire spi_req;
    input wire spi_req_erase;
    input wire spi_req_write;
    input wire spi_erase_all;
    output wire [7:0] spi_sr_rdata;
    output wire spi_grant;
    output wire spi_to_config;
    output reg spi_erase_all_go;
    input wire mcu_req;
    input wire mcu_req_write;
    input wire [5:0] mcu_page;
    output wire mcu_grant;
    output reg page_erase_go;
    output reg [7:0] page_erase_num;
    output wire debug_on;
    output wire [4:0] start_page;
    output wire nvm_reserved;

    // ----------------------------------------
    // Boot sequencer
    // ----------------------------------------
    localparam ST_UNPROTECTED_PAGE_COUNT = 3'd0;
    localparam ST_RBP = 3'd1;
    localparam ST_DBG = 3'd2;
    localparam ST_PAR = 3'd3;
    localparam ST_DONE = 3'd4;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg wait_ff;
    reg [4:0] par_cnt_ff;
    reg parity_ff;
    reg [7:0] unprotected_page_count_ff;
    reg debug_ff;
    reg stp_ff;
    reg wen_ff;
    reg ready_low_flag_ff;
    reg redir_ff;
    reg rbp_ff;
    reg rsv0_ff;
    reg [7:0] erase_reg_ff;

    wire [7:0] status_val;
    wire split;
    wire code_page;
    wire page_protected;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_UNPROTECTED_PAGE_COUNT: if (boot_rd_valid) nxt_state = ST_RBP;
            ST_RBP: if (boot_rd_valid) nxt_state = ST_DBG;
            ST_DBG: if (boot_rd_valid) nxt_state = ST_PAR;
            ST_PAR: if (boot_rd_valid && par_cnt_ff == `FCP_PARITY_BYTES - 5'd1) nxt_state = ST_DONE;
            default: nxt_state = ST_DONE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= ST_UNPROTECTED_PAGE_COUNT;
            wait_ff <= 1'b0;
            par_cnt_ff <= 5'd0;
            parity_ff <= 1'b0;
            boot_rd_en <= 1'b0;
            boot_rd_addr <= 9'h000;
        end else begin
            state_ff <= nxt_state;
            boot_rd_en <= 1'b0;
            if (state_ff != ST_DONE && !wait_ff) begin
                boot_rd_en <= 1'b1;
                wait_ff <= 1'b1;
                case (state_ff)
                    ST_UNPROTECTED_PAGE_COUNT: boot_rd_addr <= `FCP_CFG_UNPROTECTED_PAGE_COUNT;
                    ST_RBP: boot_rd_addr <= `FCP_CFG_RBP;
                    ST_DBG: boot_rd_addr <= `FCP_CFG_DEBUG;
                    default: boot_rd_addr <= 9'h1f0 + {4'h0, par_cnt_ff};
                endcase
            end else if (boot_rd_valid) begin
                wait_ff <= 1'b0;
            end
            if (state_ff == ST_PAR && boot_rd_valid) begin
                parity_ff <= parity_ff ^ (^boot_rd_data);
                par_cnt_ff <= par_cnt_ff + 5'd1;
            end
        end
    end

    // ----------------------------------------
    // Status and configuration registers
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            unprotected_page_count_ff <= `FCP_RST_PROTECT;
            debug_ff <= 1'b0;
            stp_ff <= 1'b0;
            wen_ff <= 1'b0;
            ready_low_flag_ff <= 1'b1;
            redir_ff <= 1'b0;
            rbp_ff <= 1'b1;
            rsv0_ff <= 1'b0;
            erase_reg_ff <= `FCP_RST_ERASE;
            page_erase_go <= 1'b0;
            page_erase_num <= `FCP_RST_ERASE;
            spi_erase_all_go <= 1'b0;
        end else begin
            page_erase_go <= 1'b0;
            spi_erase_all_go <= 1'b0;
            if (boot_rd_valid) begin
                case (state_ff)
                    ST_UNPROTECTED_PAGE_COUNT: unprotected_page_count_ff <= boot_rd_data;
                    ST_RBP: rbp_ff <= (boot_rd_data != `FCP_UNSET);
                    ST_DBG: debug_ff <= (boot_rd_data != `FCP_UNSET);
                    default: ;
                endcase
            end
            if (state_ff == ST_PAR && nxt_state == ST_DONE) begin
                stp_ff <= parity_ff ^ (^boot_rd_data);
                ready_low_flag_ff <= 1'b0;
            end
            if (sfr_wr && sfr_addr == `FCP_ADDR_STATUS) begin
                wen_ff <= sfr_wdata[`FCP_BIT_WEN];
                redir_ff <= sfr_wdata[`FCP_BIT_REDIR];
                rsv0_ff <= sfr_wdata[`FCP_BIT_RSV0];
                if (!rbp_ff && sfr_wdata[`FCP_BIT_DEBUG]) debug_ff <= 1'b1;
            end else if (sfr_wr && sfr_addr == `FCP_ADDR_ERASE) begin
                erase_reg_ff <= sfr_wdata;
                if (sfr_wdata < `FCP_ERASE_LIMIT && mcu_grant_erase(sfr_wdata)) begin
                    page_erase_go <= 1'b1;
                    page_erase_num <= sfr_wdata;
                end
            end
            if (spi_sr_wr) begin
                wen_ff <= spi_sr_wdata[`FCP_BIT_WEN];
                redir_ff <= spi_sr_wdata[`FCP_BIT_REDIR];
            end
            if (spi_wren) wen_ff <= 1'b1;
            if (spi_wrdis) wen_ff <= 1'b0;
            if (spi_rbp_cmd && wen_ff) rbp_ff <= 1'b1;
            if (spi_req && spi_grant && (spi_req_erase || spi_req_write)) wen_ff <= 1'b0;
            if (spi_erase_all && wen_ff) begin
                spi_erase_all_go <= 1'b1;
                rbp_ff <= 1'b0;
                debug_ff <= 1'b0;
                unprotected_page_count_ff <= `FCP_UNSET;
                wen_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Protection decisions
    // ----------------------------------------
    function mcu_grant_erase;
        input [7:0] pg;
        begin
            mcu_grant_erase = !(unprotected_page_count_ff < `FCP_CODE_PAGES && pg < `FCP_CODE_PAGES && pg >= unprotected_page_count_ff);
        end
    endfunction

    assign split = (unprotected_page_count_ff < `FCP_CODE_PAGES);
    assign code_page = ({2'b00, mcu_page} < `FCP_CODE_PAGES);
    assign page_protected = split && code_page && ({2'b00, mcu_page} >= unprotected_page_count_ff);
    assign mcu_grant = mcu_req && (!mcu_req_write || !page_protected);
    assign spi_to_config = redir_ff && !spi_erase_all;
    assign spi_grant = spi_req && !ready_low_flag_ff && (spi_to_config ?
        (!rbp_ff || (!spi_req_erase && !spi_req_write)) :
        !rbp_ff) && (!(spi_req_erase || spi_req_write) || wen_ff);
    assign debug_on = debug_ff;
    assign start_page = (split && stp_ff) ? unprotected_page_count_ff[4:0] : 5'd0;
    assign nvm_reserved = split;

    // ----------------------------------------
    // Register read-back
    // ----------------------------------------
    assign status_val = {debug_ff, stp_ff, wen_ff, ready_low_flag_ff, redir_ff, rbp_ff, 1'b1, rsv0_ff};
    assign spi_sr_rdata = status_val;

    always @(posedge sys_clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_addr == `FCP_ADDR_STATUS) begin
            sfr_rdata <= status_val;
        end else if (sfr_addr == `FCP_ADDR_PROTECT) begin
            sfr_rdata <= {1'b1, unprotected_page_count_ff[6:0]};
        end else if (sfr_addr == `FCP_ADDR_ERASE) begin
            sfr_rdata <= erase_reg_ff;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end
endmodule // fcp_flash_config

// *** test/fcp_flash_config_props.sv ***
`timescale 1ns/1ps
module fcp_flash_config_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic spi_sr_wr,
    input wire logic spi_rbp_cmd,
    input wire logic spi_req,
    input wire logic spi_req_erase,
    input wire logic spi_req_write,
    input wire logic spi_erase_all,
    input wire logic [7:0] spi_sr_rdata,
    input wire logic spi_grant,
    input wire logic spi_to_config,
    input wire logic spi_erase_all_go,
    input wire logic page_erase_go,
    input wire logic [7:0] page_erase_num,
    input wire logic debug_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // Checks
    // ----
    a_reset_status: assert property (disable iff (1'b0) rst |=> spi_sr_rdata == 8'h16)
        else $error("status not at reset value");
    a_erase_data_page: assert property (sfr_wr && sfr_addr == 8'hfa && sfr_wdata inside {[8'h20:8'h23]}
        |=> page_erase_go && page_erase_num == $past(sfr_wdata))
        else $error("data page erase not issued");
    a_erase_refused: assert property (sfr_wr && sfr_addr == 8'hfa && sfr_wdata >= 8'h24 |=> !page_erase_go)
        else $error("erase issued for bad page");
    a_spi_gate: assert property (spi_req && spi_grant && (spi_req_erase || spi_req_write)
        |-> spi_sr_rdata[5] && !spi_sr_rdata[2])
        else $error("spi op granted without latch or under lock");
    a_wen_clears: assert property (spi_req && spi_grant && (spi_req_erase || spi_req_write) |=> !spi_sr_rdata[5])
        else $error("write latch kept after spi op");
    a_boot_no_grant: assert property (spi_sr_rdata[4] |-> !spi_grant)
        else $error("spi granted before boot done");
    a_debug_sticky: assert property (spi_sr_rdata[7] && !spi_erase_all |=> spi_sr_rdata[7])
        else $error("debug flag cleared");
    a_status_write_cmd_locked: assert property (spi_sr_wr && !sfr_wr && !spi_erase_all && !spi_rbp_cmd && !spi_sr_rdata[4]
        |=> $stable({spi_sr_rdata[7:6], spi_sr_rdata[4], spi_sr_rdata[2]}))
        else $error("status write touched locked bits");
    a_erase_all_go: assert property (spi_erase_all && spi_sr_rdata[5] && !spi_sr_rdata[4]
        |=> spi_erase_all_go && !spi_sr_rdata[2])
        else $error("erase all not issued");
    a_debug_pin: assert property (debug_on == spi_sr_rdata[7])
        else $error("debug output differs from flag");
    a_redirect: assert property (spi_req && spi_sr_rdata[3] |-> spi_to_config)
        else $error("redirect not applied");
endmodule // fcp_flash_config_props
bind fcp_flash_config fcp_flash_config_props u_fcp_flash_config_props (.*);

// *** test/fcp_cfg_page_model.sv ***
`timescale 1ns/1ps
module fcp_cfg_page_model (
    input wire logic sys_clk,
    input wire logic [8:0] boot_rd_addr,
    input wire logic boot_rd_en,
    input wire logic slow,
    input wire logic [7:0] cfg_count,
    input wire logic [7:0] cfg_rbp,
    input wire logic [7:0] cfg_dbg,
    input wire logic [15:0] cfg_par,
    output logic [7:0] boot_rd_data,
    output logic boot_rd_valid
);
    logic [8:0] addr_ff;
    logic [1:0] wait_ff;
    logic busy_ff = 0;
    // ----
    // Config page read, tuning area never written
    // ----
    initial boot_rd_valid = 0;
    initial boot_rd_data = 8'h00;
    always @(posedge sys_clk) begin
        boot_rd_valid <= 1'b0;
        boot_rd_data <= ~boot_rd_data;
        if (boot_rd_en) begin
            addr_ff <= boot_rd_addr;
            wait_ff <= slow ? 2'h2 : 2'h0;
            busy_ff <= 1'b1;
        end else if (busy_ff && wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            boot_rd_valid <= 1'b1;
            case (addr_ff)
                9'h020: boot_rd_data <= cfg_count;
                9'h023: boot_rd_data <= cfg_rbp;
                9'h024: boot_rd_data <= cfg_dbg;
                default: boot_rd_data <= (addr_ff >= 9'h1f0) ? {7'h00, cfg_par[addr_ff[3:0]]} : 8'hff;
            endcase
        end
    end
endmodule // fcp_cfg_page_model

// *** test/test_fcp_flash_config.sv ***
`timescale 1ns/1ps
module test_fcp_flash_config;
    logic sys_clk = 0, rst = 1, boot_rd_en, boot_rd_valid, sfr_wr = 0, spi_sr_wr = 0, spi_wren = 0, spi_wrdis = 0;
    logic spi_rbp_cmd = 0, spi_req = 0, spi_req_erase = 0, spi_req_write = 0, spi_erase_all = 0, mcu_req = 0;
    logic mcu_req_write = 0, spi_grant, spi_to_config, spi_erase_all_go, mcu_grant, page_erase_go, debug_on;
    logic nvm_reserved, slow = 1;
    logic [8:0] boot_rd_addr;
    logic [7:0] boot_rd_data, sfr_addr = 0, sfr_wdata = 0, sfr_rdata, spi_sr_wdata = 0, spi_sr_rdata, page_erase_num;
    logic [7:0] cfg_count = 8'h0c, cfg_rbp = 8'hff, cfg_dbg = 8'hff;
    logic [15:0] cfg_par = 16'h0001;
    logic [5:0] mcu_page = 0;
    logic [4:0] start_page;
    int err_count = 0, checked = 0, cyc = 0;
    always #2.5 sys_clk = ~sys_clk;
    fcp_flash_config u_fcp_flash_config (.*);
    fcp_cfg_page_model u_fcp_cfg_page_model (.*);
    // ----
    // Helpers
    // ----
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic boot();
        rst = 1;
        tick(8);
        rst = 0;
        for (int i = 0; i < 200 && spi_sr_rdata[4] !== 1'b0; i++) tick();
    endtask
    task automatic sfr(logic [7:0] a, logic [7:0] d, logic w);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        tick();
        sfr_wr = 0;
    endtask
    task automatic sr_write(logic [7:0] d);
        spi_sr_wdata = d;
        spi_sr_wr = 1;
        tick();
        spi_sr_wr = 0;
    endtask
    task automatic finish_test();
        $display("err_count=%0d checked=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk) if (++cyc == 3000) begin
        err_count++;
        finish_test();
    end
    // ----
    // Scenarios
    // ----
    task automatic t_split_boot();
        boot();
        chk(spi_sr_rdata & 8'hfc, 8'h40);
        chk(start_page, 8'h0c);
        sfr(8'hf9, 8'h00, 0);
        chk(sfr_rdata[6:0], 8'h0c);
        chk(nvm_reserved, 1);
    endtask
    task automatic t_mcu_protect();
        byte unsigned v[6] = '{8'h0b, 8'h0c, 8'h1f, 8'h20, 8'h23, 8'h24};
        mcu_req = 1;
        mcu_req_write = 1;
        foreach (v[i]) begin
            mcu_page = v[i][5:0];
            #1 if (v[i] < 8'h20) chk(mcu_grant, v[i] < 8'h0c);
            sfr(8'hfa, v[i], 1);
            chk(page_erase_go, v[i] < 8'h0c || (v[i] >= 8'h20 && v[i] < 8'h24));
            if (page_erase_go === 1'b1) chk(page_erase_num, v[i]);
        end
        mcu_req = 0;
    endtask
    task automatic t_spi_latch();
        spi_req = 1;
        spi_req_write = 1;
        #1 chk(spi_grant, 0);
        spi_wren = 1;
        tick();
        spi_wren = 0;
        chk(spi_grant, 1);
        tick();
        spi_req = 0;
        spi_req_write = 0;
        chk(spi_sr_rdata[5], 0);
        sr_write(8'hff);
        chk(spi_sr_rdata & 8'hfc, 8'h68);
        spi_req = 1;
        #1 chk(spi_to_config, 1);
        spi_req = 0;
        sfr(8'hf8, 8'h80, 1);
        chk(debug_on, 1);
        sfr(8'hf8, 8'h00, 1);
        chk(spi_sr_rdata & 8'hfc, 8'hc0);
    endtask
    task automatic t_lock_boot();
        cfg_count = 8'hff;
        cfg_rbp = 8'h00;
        cfg_dbg = 8'h00;
        slow = 0;
        boot();
        chk(spi_sr_rdata & 8'hfc, 8'hc4);
        chk(debug_on, 1);
        mcu_req = 1;
        mcu_page = 6'h1f;
        #1 chk(mcu_grant, 1);
        mcu_req = 0;
        sr_write(8'h20);
        spi_req = 1;
        #1 chk(spi_grant, 0);
        spi_req_write = 1;
        #1 chk(spi_grant, 0);
        spi_req_write = 0;
        spi_req = 0;
        sr_write(8'h28);
        spi_req = 1;
        #1 chk(spi_grant, 1);
        spi_req = 0;
        spi_erase_all = 1;
        tick();
        spi_erase_all = 0;
        chk({spi_erase_all_go, spi_sr_rdata[2]}, 8'h02);
        spi_wren = 1;
        tick();
        spi_wren = 0;
        spi_rbp_cmd = 1;
        tick();
        spi_rbp_cmd = 0;
        chk(spi_sr_rdata[2], 1);
    endtask
    initial begin
        t_split_boot();
        t_mcu_protect();
        t_spi_latch();
        t_lock_boot();
        finish_test();
    end
endmodule // test_fcp_flash_config
